// ==== trr_pkg.sv ====
// Package for the targeted refresh and row repair sequencer.
// Assumes a single 50 MHz clock; commands arrive already decoded.
package trr_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// Command codes on the decoded command port
	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_ACT,
		CMD_PRE,
		CMD_PRE_ALL,
		CMD_MRW,
		CMD_REF,
		CMD_OTHER
	} trr_cmd_t;
	// Mode register addresses and fields
	localparam logic [5:0] HAMMER_MR_ADDR   = 6'h18;
	localparam logic [5:0] REPAIR_MR_ADDR   = 6'h04;
	localparam int         HAMMER_EN_POS    = 7;
	localparam int         HAMMER_BANK_LSB  = 4;
	localparam int         REPAIR_EN_POS    = 4;
	localparam int         ACT_COUNT        = 3;
	// Reset values
	localparam logic [7:0] HAMMER_MR_RESET  = 8'h00;
	localparam logic [2:0] BANK_RESET       = 3'h0;
	// Timing
	localparam int MRD_NS        = 14;
	localparam int TRP_NS        = 18;
	localparam int MRD_CYCLES    = (MRD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int TRP_CYCLES    = (TRP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CLEAR_CYCLES  = MRD_CYCLES + TRP_CYCLES;
	localparam int PGM_MS        = 1000;
	localparam int PGM_CYCLES    = PGM_MS * (1000000 / CLK_PERIOD_NS);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_CLEARING
	} trr_state_t;
endpackage : trr_pkg

// ==== trr_delay_timer.sv ====
// Down counter that flags when a loaded delay has run out.
// Assumes load and count are synchronous to clk.
module trr_delay_timer
	import trr_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] loadValue,
	// Status
	output logic                  expired
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	always_comb begin
		next_count = count;
		if (load) begin
			next_count = loadValue;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign expired = (count == '0) && !load;
endmodule : trr_delay_timer

// ==== trr_sequencer.sv ====
// Device-side tracker for targeted row refresh and post package repair.
// Assumes commands arrive decoded, one per cycle, synchronous to clk.
//
// How it works
// - Run completes after three aggressor activates and three precharges.
// - Precharge-all in the mode counts as an aggressor precharge.
// - After the second activate other banks may take commands again.
// - Device clears mode itself tRP plus mode_register_delay after it.
// - Aggressor activates in the mode leave refresh counter unchanged.
// - One repair per bank; a reset clears bankRepaired; guard against stray entry.
// - One repair activate programs exactly one replacement row per die.
// - Only a clearing hammer register write is accepted mid run.
module trr_sequencer
	import trr_pkg::*;
#(
	parameter int BANKS = 8,
	parameter int PGM_COUNT = PGM_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Decoded command
	input  wire trr_cmd_t    cmd,
	input  wire logic [2:0]  cmdBank,
	input  wire logic [5:0]  cmdMrAddr,
	input  wire logic [7:0]  cmdMrData,
	// Mode status
	output logic             hammerActive,
	output logic [2:0]       aggressorBank,
	output logic [1:0]       actCount,
	output logic [1:0]       preCount,
	output logic             refreshCountEn,
	// Repair status
	output logic             repairEnable,
	output logic             repairBusy,
	output logic             repairRowFuse,
	output logic [BANKS-1:0] bankRepaired
);
	// Bank field is three bits wide, so eight banks exactly
	if (BANKS != 8) begin : g_bad_banks
		$error("BANKS must be 8");
	end
	if (PGM_COUNT < 1) begin : g_bad_pgm
		$error("PGM_COUNT must be positive");
	end

	// Counter sized from the parameter so any programming time fits
	localparam int PGM_W = $clog2(PGM_COUNT + 1);

	trr_state_t        state;
	trr_state_t        next_state;
	logic [2:0]        next_aggressorBank;
	logic [1:0]        next_actCount;
	logic [1:0]        next_preCount;
	logic              next_refreshCountEn;
	logic              next_repairEnable;
	logic              next_repairBusy;
	logic              next_repairRowFuse;
	logic [BANKS-1:0]  next_bankRepaired;
	logic              repairSpent;
	logic              next_repairSpent;
	logic [PGM_W-1:0]  pgmCount;
	logic [PGM_W-1:0]  next_pgmCount;
	logic              clearLoad;
	logic              clearDone;
	logic              isAggPre;
	logic              hammerWrite;
	logic              repairWrite;

	// Shared delay for self clearing after the third precharge
	trr_delay_timer #(
		.WIDTH (4)
	) u_clear_timer (
		.clk       (clk),
		.rst_n     (rst_n),
		.load      (clearLoad),
		.loadValue (4'(CLEAR_CYCLES)),
		.expired   (clearDone)
	);

	// Mode register writes decoded by address
	assign hammerWrite = (cmd == CMD_MRW) && (cmdMrAddr == HAMMER_MR_ADDR);
	assign repairWrite = (cmd == CMD_MRW) && (cmdMrAddr == REPAIR_MR_ADDR);
	// Precharge-all also hits the aggressor bank
	assign isAggPre = (cmd == CMD_PRE_ALL) ||
		((cmd == CMD_PRE) && (cmdBank == aggressorBank));

	always_comb begin
		next_state          = state;
		next_aggressorBank  = aggressorBank;
		next_actCount       = actCount;
		next_preCount       = preCount;
		next_refreshCountEn = 1'b0;
		clearLoad           = 1'b0;
		case (state)
			ST_IDLE: begin
				// Repair enabled blocks entry, so the two modes never mix
				if (hammerWrite && cmdMrData[HAMMER_EN_POS] && !repairEnable) begin
					next_state         = ST_ACTIVE;
					next_aggressorBank = cmdMrData[HAMMER_BANK_LSB +: 3];
					next_actCount      = 2'h0;
					next_preCount      = 2'h0;
				end
				// Refresh counter only steps outside the mode
				next_refreshCountEn = (cmd == CMD_REF);
			end
			ST_ACTIVE: begin
				// Bank latched at entry; later writes cannot move it
				if (hammerWrite && !cmdMrData[HAMMER_EN_POS]) begin
					next_state    = ST_IDLE;
					next_actCount = 2'h0;
					next_preCount = 2'h0;
				end else if (cmd == CMD_ACT && cmdBank == aggressorBank) begin
					// Other banks pass untouched; activates past three ignored
					if (actCount != 2'(ACT_COUNT)) begin
						next_actCount = actCount + 2'h1;
					end
				end else if (isAggPre && actCount > preCount) begin
					next_preCount = preCount + 2'h1;
					if (preCount == 2'(ACT_COUNT - 1)) begin
						next_state = ST_CLEARING;
						clearLoad  = 1'b1;
					end
				end
			end
			ST_CLEARING: begin
				// Self clear after tRP plus mode register delay
				if (hammerWrite && !cmdMrData[HAMMER_EN_POS]) begin
					// Host may also close the mode by a clearing write
					next_state = ST_IDLE;
				end else if (clearDone) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Port hammerActive follows the next state, straight from a flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state          <= ST_IDLE;
			aggressorBank  <= BANK_RESET;
			actCount       <= 2'h0;
			preCount       <= 2'h0;
			refreshCountEn <= 1'b0;
			hammerActive   <= 1'b0;
		end else begin
			state          <= next_state;
			aggressorBank  <= next_aggressorBank;
			actCount       <= next_actCount;
			preCount       <= next_preCount;
			refreshCountEn <= next_refreshCountEn;
			hammerActive   <= (next_state != ST_IDLE);
		end
	end

	// Repair: fuse a spare per bank, once; a reset ends the procedure
	always_comb begin
		next_repairEnable  = repairEnable;
		next_repairBusy    = repairBusy;
		next_repairRowFuse = 1'b0;
		next_bankRepaired  = bankRepaired;
		next_pgmCount      = pgmCount;
		next_repairSpent   = repairSpent;
		if (repairWrite && state == ST_IDLE && !repairBusy) begin
			next_repairEnable = cmdMrData[REPAIR_EN_POS];
		end
		if (repairBusy) begin
			if (pgmCount != '0) begin
				next_pgmCount = pgmCount - 1'b1;
			end else if (cmd == CMD_PRE || cmd == CMD_PRE_ALL) begin
				next_repairBusy = 1'b0;
			end
		end else if (repairEnable && !repairSpent && cmd == CMD_ACT &&
				!bankRepaired[cmdBank]) begin
			// Fuse is one-shot per bank; only a reset clears bankRepaired
			next_repairBusy            = 1'b1;
			// One row per procedure; only a reset opens the next one
			next_repairSpent           = 1'b1;
			next_repairRowFuse         = 1'b1;
			next_bankRepaired[cmdBank] = 1'b1;
			next_pgmCount              = PGM_W'(PGM_COUNT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// A reset ends any repair procedure in flight
			repairEnable  <= 1'b0;
			repairSpent   <= 1'b0;
			repairBusy    <= 1'b0;
			repairRowFuse <= 1'b0;
			bankRepaired  <= '0;
			pgmCount      <= '0;
		end else begin
			repairEnable  <= next_repairEnable;
			repairSpent   <= next_repairSpent;
			repairBusy    <= next_repairBusy;
			repairRowFuse <= next_repairRowFuse;
			bankRepaired  <= next_bankRepaired;
			pgmCount      <= next_pgmCount;
		end
	end
endmodule : trr_sequencer

// ==== trr_sequencer_monitor.sv ====
// Concurrent checks on the trr_sequencer ports.
// Assumes binding onto every trr_sequencer instance.
module trr_sequencer_monitor
	import trr_pkg::*;
#(
	parameter int BANKS     = 8,
	parameter int PGM_COUNT = PGM_CYCLES
) (
	// Clock and reset
	input wire logic             clk,
	input wire logic             rst_n,
	// Command
	input wire trr_cmd_t         cmd,
	input wire logic [2:0]       cmdBank,
	input wire logic [5:0]       cmdMrAddr,
	input wire logic [7:0]       cmdMrData,
	// Status
	input wire logic             hammerActive,
	input wire logic [2:0]       aggressorBank,
	input wire logic [1:0]       actCount,
	input wire logic [1:0]       preCount,
	input wire logic             refreshCountEn,
	input wire logic             repairEnable,
	input wire logic             repairBusy,
	input wire logic             repairRowFuse,
	input wire logic [BANKS-1:0] bankRepaired
);
	timeunit 1ns;
	timeprecision 1ps;
	logic hmw;
	assign hmw = cmd == CMD_MRW && cmdMrAddr == HAMMER_MR_ADDR;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_act_counted: assert property (
		hammerActive && cmd == CMD_ACT && cmdBank == aggressorBank
		&& actCount != 2'h3 |=> actCount == $past(actCount) + 2'h1)
		else $error("aggressor activate not counted");
	a_precharge_all_counted: assert property (
		hammerActive && cmd == CMD_PRE_ALL && preCount != actCount
		|=> preCount == $past(preCount) + 2'h1)
		else $error("precharge all not counted");
	a_self_clear: assert property (
		$rose(preCount == 2'h3) |-> hammerActive [*2] ##[1:3] !hammerActive)
		else $error("mode did not clear on time");
	a_no_refresh: assert property (
		hammerActive && cmd == CMD_ACT |=> !refreshCountEn)
		else $error("aggressor activate counted as refresh");
	a_entry_refused: assert property (
		!hammerActive && repairEnable && hmw |=> !hammerActive)
		else $error("hammer entry taken during repair");
	a_abort_idle: assert property (
		hammerActive && hmw && !cmdMrData[7] |=> !hammerActive)
		else $error("clearing write did not abort");
	a_repair_locked: assert property (
		hammerActive && cmd == CMD_MRW && cmdMrAddr == REPAIR_MR_ADDR
		|=> $stable(repairEnable))
		else $error("repair write taken in hammer mode");
	a_fuse_once: assert property (
		repairEnable && !repairBusy && cmd == CMD_ACT
		&& bankRepaired[cmdBank] |=> !repairRowFuse)
		else $error("fused bank fused again");
	a_fuse_single: assert property (
		repairRowFuse |-> $countones(bankRepaired ^ $past(bankRepaired)) == 1)
		else $error("fuse pulse without exactly one new row");
endmodule : trr_sequencer_monitor
bind trr_sequencer trr_sequencer_monitor #(
	.BANKS(BANKS),
	.PGM_COUNT(PGM_COUNT)
) i_trr_sequencer_monitor (.clk, .rst_n, .cmd, .cmdBank, .cmdMrAddr,
	.cmdMrData, .hammerActive, .aggressorBank, .actCount, .preCount,
	.refreshCountEn, .repairEnable, .repairBusy, .repairRowFuse,
	.bankRepaired);

// ==== trr_host_model.sv ====
// Host controller model driving the decoded command port.
// Assumes callers sit just after a rising clock edge.
module trr_host_model
	import trr_pkg::*;
(
	// Clock
	input wire logic   clk,
	// Command
	output trr_cmd_t   cmd,
	output logic [2:0] cmdBank,
	output logic [5:0] cmdMrAddr,
	output logic [7:0] cmdMrData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd = CMD_NONE;
		cmdBank = 3'h0;
		cmdMrAddr = 6'h00;
		cmdMrData = 8'h00;
	end
	// Gap g drives CMD_NONE with inverted data; g models mode_register_delay, tRAS, tRP and program waits
	task automatic issue(input trr_cmd_t c, input logic [2:0] b,
		input logic [5:0] a, input logic [7:0] d, input int g);
		cmd = c;
		cmdBank = b;
		cmdMrAddr = a;
		cmdMrData = d;
		@(posedge clk);
		#1;
		if (g > 0) begin
			cmd = CMD_NONE;
			cmdMrData = ~d;
			repeat (g) @(posedge clk);
			#1;
		end
	endtask : issue
endmodule : trr_host_model

// ==== trr_sequencer_tb_top.sv ====
// Self-checking bench for trr_sequencer.
// Assumes trr_host_model drives the command port.
module trr_sequencer_tb_top
	import trr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PGM = 20;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	trr_cmd_t   cmd;
	logic [2:0] cmdBank, aggressorBank;
	logic [5:0] cmdMrAddr;
	logic [7:0] cmdMrData, bankRepaired;
	logic [1:0] actCount, preCount;
	logic       hammerActive, refreshCountEn, repairEnable;
	logic       repairBusy, repairRowFuse;
	int         n_fail = 0;
	int         n_compared = 0;
	always #10 clk = ~clk;
	trr_host_model i_trr_host_model (.clk, .cmd, .cmdBank, .cmdMrAddr,
		.cmdMrData);
	trr_sequencer #(.PGM_COUNT(PGM)) i_trr_sequencer (.clk, .rst_n, .cmd,
		.cmdBank, .cmdMrAddr, .cmdMrData, .hammerActive, .aggressorBank,
		.actCount, .preCount, .refreshCountEn, .repairEnable, .repairBusy,
		.repairRowFuse, .bankRepaired);
	task automatic go(input trr_cmd_t c, input logic [2:0] b,
		input logic [5:0] a, input logic [7:0] d, input int g);
		i_trr_host_model.issue(c, b, a, d, g);
	endtask : go
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		chk({hammerActive, actCount, preCount, refreshCountEn, repairEnable,
			repairBusy}, 8'h00);
		chk(bankRepaired, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_hammer();
		int n;
		go(CMD_MRW, 3'h0, HAMMER_MR_ADDR, 8'hd0, 1);
		chk({hammerActive, 4'h0, aggressorBank}, 8'h85);
		for (int i = 0; i < 3; i++) begin
			go(CMD_ACT, 3'h5, 6'h00, 8'h00, i);
			chk(8'({refreshCountEn, actCount, preCount}), 8'(5 * i + 4));
			if (i == 1)
				go(CMD_PRE_ALL, 3'h0, 6'h00, 8'h00, 0);
			else
				go(CMD_PRE, 3'h5, 6'h00, 8'h00, 0);
			chk(8'({actCount, preCount}), 8'(5 * i + 5));
		end
		n = 0;
		while (hammerActive === 1'b1 && n < 9) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(8'(n), 8'(CLEAR_CYCLES + 1));
		if (n == 9)
			final_report();
		else
			$display("test hammer done");
	endtask : t_hammer
	task automatic t_abort();
		go(CMD_MRW, 3'h0, HAMMER_MR_ADDR, 8'ha0, 1);
		go(CMD_ACT, 3'h2, 6'h00, 8'h00, 0);
		go(CMD_MRW, 3'h0, REPAIR_MR_ADDR, 8'h10, 0);
		chk({4'h0, repairEnable, hammerActive, actCount}, 8'h05);
		go(CMD_MRW, 3'h0, HAMMER_MR_ADDR, 8'h70, 1);
		chk({7'h0, hammerActive}, 8'h00);
		repeat (3) go(CMD_PRE, 3'h2, 6'h00, 8'h00, 1);
		go(CMD_REF, 3'h0, 6'h00, 8'h00, 0);
		chk({7'h0, refreshCountEn}, 8'h01);
		$display("test abort done");
	endtask : t_abort
	task automatic t_repair();
		go(CMD_MRW, 3'h0, REPAIR_MR_ADDR, 8'h10, 1);
		go(CMD_MRW, 3'h0, HAMMER_MR_ADDR, 8'h80, 1);
		chk({6'h0, repairEnable, hammerActive}, 8'h02);
		go(CMD_ACT, 3'h3, 6'h00, 8'h00, 0);
		chk({repairRowFuse, repairBusy, bankRepaired[5:0]}, 8'hc8);
		go(CMD_NONE, 3'h0, 6'h00, 8'h00, PGM);
		chk({repairRowFuse, repairBusy, bankRepaired[5:0]}, 8'h48);
		go(CMD_PRE, 3'h3, 6'h00, 8'h00, 1);
		go(CMD_ACT, 3'h3, 6'h00, 8'h00, 0);
		chk({repairRowFuse, repairBusy, bankRepaired[5:0]}, 8'h08);
		go(CMD_ACT, 3'h4, 6'h00, 8'h00, 0);
		chk({repairRowFuse, repairBusy, bankRepaired[5:0]}, 8'h08);
		go(CMD_MRW, 3'h0, REPAIR_MR_ADDR, 8'h00, PGM);
		chk({7'h0, repairEnable}, 8'h00);
		$display("test repair done");
	endtask : t_repair
	initial begin
		t_reset();
		t_hammer();
		t_abort();
		t_hammer();
		t_repair();
		t_reset();
		final_report();
	end
endmodule : trr_sequencer_tb_top
